// >>> verilog/interval_register_bank.sv
// Purpose: Host register bank of a two-channel interval converter
// Assumes: Bus pins synchronous to CLK, measuring core outside
// Notes:   16-bit results are read as two bytes, low byte first
module interval_register_bank
    import interval_bank_pkg::*;
(
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // Host bus
    input  wire logic [3:0] ADDR,
    input  wire logic       ADDR_LATCH,
    input  wire logic       CHIP_SELECT_LOW,
    input  wire logic       READ_STROBE_LOW,
    input  wire logic       WRITE_STROBE_LOW,
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE,
    // Interrupt
    output logic            IRQ_OUT,
    // Measuring core
    input  wire core_type   CORE,
    output ctrl_type        CTRL,
    output pulse_type       PULSE
);

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    logic [3:0]  addr;
    logic        wr_low_q;
    logic        rd_low_q;
    logic [7:0]  wr_data;
    logic        wr_stb;
    logic        rd_end;
    logic        por_wipe;
    logic        byte_high;
    logic [7:0]  wr_reg [0:WRITE_REGS-1];
    logic [15:0] result [0:RESULT_WORDS-1];
    logic [7:0]  pll_ref;
    logic        overflow_flag;
    logic        irq_set;
    logic        irq_clr;
    logic [7:0]  status_one;
    logic [7:0]  rd_byte;
    logic [15:0] rd_word;
    ctrl_type    next_ctrl;

    // Write completes on the rising write strobe under chip select
    assign wr_stb = !wr_low_q && WRITE_STROBE_LOW && !CHIP_SELECT_LOW;
    assign rd_end = !rd_low_q && READ_STROBE_LOW && !CHIP_SELECT_LOW;
    assign por_wipe = wr_stb && (addr == ADR_INIT) && (wr_data[7:4] == POR_PATTERN);

    // Address taken while the latch strobe is high, held otherwise
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            addr <= 4'h0;
        end else if (ADDR_LATCH) begin
            addr <= ADDR;
        end
    end

    // Strobe history and write data capture
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_low_q <= 1'b1;
            rd_low_q <= 1'b1;
            wr_data  <= 8'h00;
        end else begin
            wr_low_q <= WRITE_STROBE_LOW;
            rd_low_q <= READ_STROBE_LOW;
            if (!WRITE_STROBE_LOW) begin
                wr_data <= DATA_IN; // Last byte seen before the rise
            end
        end
    end

    // ------------------------------------------------------------
    // Write registers
    // ------------------------------------------------------------
    // Register file, wiped by reset or the power-on pattern
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < WRITE_REGS; i++) begin
                wr_reg[i] <= REG_RESET;
            end
        end else if (por_wipe) begin
            for (int i = 0; i < WRITE_REGS; i++) begin
                wr_reg[i] <= REG_RESET;
            end
        end else if (wr_stb && (addr <= ADR_MULT_HIGH)) begin
            wr_reg[addr] <= wr_data;
        end
    end

    // Field decode towards the core
    always_comb begin
        next_ctrl = '0;
        // Command register
        next_ctrl.range_two_select  = wr_reg[ADR_COMMAND][RANGE_BIT];
        next_ctrl.stop_two_polarity = wr_reg[ADR_COMMAND][2];
        next_ctrl.stop_one_polarity = wr_reg[ADR_COMMAND][1];
        next_ctrl.start_polarity    = wr_reg[ADR_COMMAND][0];
        // Resolution register
        next_ctrl.resolution_adjust = wr_reg[ADR_RESOLUTION][7];
        next_ctrl.start_enable      = !wr_reg[ADR_RESOLUTION][7];
        next_ctrl.high_resolution   = wr_reg[ADR_RESOLUTION][6];
        next_ctrl.high_res_adjust   = wr_reg[ADR_RESOLUTION][5:0];
        // Readout selection
        next_ctrl.upper_readout_select = wr_reg[ADR_HIT_SELECT][7:4];
        next_ctrl.lower_readout_select = wr_reg[ADR_HIT_SELECT][3:0];
        // PLL tuning and clocks
        next_ctrl.pll_tune_factor   = wr_reg[ADR_PLL_ADJUST];
        next_ctrl.cal_clock_divider = wr_reg[ADR_CLOCK_DIV][7:5];
        next_ctrl.pll_phase_invert  = wr_reg[ADR_CLOCK_DIV][4];
        next_ctrl.pll_track_mode    = wr_reg[ADR_CLOCK_DIV][3];
        next_ctrl.pll_ref_divider   = wr_reg[ADR_CLOCK_DIV][2:0];
        // Component measurement
        next_ctrl.component_port_count    = wr_reg[ADR_COMPONENT][7:5];
        next_ctrl.single_port             = wr_reg[ADR_COMPONENT][4];
        next_ctrl.capacitor_select        = wr_reg[ADR_COMPONENT][3];
        next_ctrl.component_clock_divider = wr_reg[ADR_COMPONENT][2:0];
        // Interrupt and mode register
        next_ctrl.irq_on_overflow     = wr_reg[ADR_IRQ_MODE][7];
        next_ctrl.queuing_enable      = wr_reg[ADR_IRQ_MODE][6] && !wr_reg[ADR_COMMAND][RANGE_BIT];
        next_ctrl.restart_mode_enable = wr_reg[ADR_IRQ_MODE][5];
        next_ctrl.noise_enable        = wr_reg[ADR_IRQ_MODE][4];
        next_ctrl.component_start     = wr_reg[ADR_IRQ_MODE][3];
        next_ctrl.external_transistor = wr_reg[ADR_IRQ_MODE][2];
        next_ctrl.alu_speed           = wr_reg[ADR_IRQ_MODE][1:0];
        // Hit limits saturate at four
        next_ctrl.half_resolution = wr_reg[ADR_HIT_LIMIT][7];
        next_ctrl.spike_suppress  = wr_reg[ADR_HIT_LIMIT][6];
        next_ctrl.channel_two_limit = (wr_reg[ADR_HIT_LIMIT][5:3] > HIT_MAX) ?
                                      HIT_MAX : wr_reg[ADR_HIT_LIMIT][5:3];
        next_ctrl.channel_one_limit = (wr_reg[ADR_HIT_LIMIT][2:0] > HIT_MAX) ?
                                      HIT_MAX : wr_reg[ADR_HIT_LIMIT][2:0];
        // Multiplication factor, low byte at the lowest address
        next_ctrl.multiply_factor = {wr_reg[ADR_MULT_HIGH], wr_reg[ADR_MULT_MID], wr_reg[ADR_MULT_LOW]};
    end

    // Registered control towards the core
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CTRL <= '0;
        end else begin
            CTRL <= next_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Action pulses
    // ------------------------------------------------------------
    // One-cycle commands raised by writes and by finished measurements
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PULSE <= '0;
        end else begin
            PULSE.cal_run <= (wr_stb && (addr == ADR_COMMAND) && wr_data[CAL_BIT])
                          || (CORE.measure_done && wr_reg[ADR_COMMAND][AUTO_CAL_BIT]);
            PULSE.alu_calibrate <= wr_stb && (addr == ADR_COMMAND) && wr_data[ALU_CAL_BIT];
            PULSE.do_multiply   <= wr_stb && (addr == ADR_COMMAND) && wr_data[MULT_BIT];
            PULSE.init_measure  <= wr_stb && (addr == ADR_INIT) && wr_data[INIT_TDC_BIT];
            PULSE.init_alu      <= wr_stb && (addr == ADR_INIT) && wr_data[INIT_ALU_BIT];
            PULSE.clock_noise   <= wr_stb && (addr == ADR_INIT) && wr_data[NOISE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Results and status
    // ------------------------------------------------------------
    // Result words from the core, dropped on measuring-unit init
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            for (int i = 0; i < RESULT_WORDS; i++) begin
                result[i] <= 16'h0000;
            end
        end else if (PULSE.init_measure) begin
            for (int i = 0; i < RESULT_WORDS; i++) begin
                result[i] <= 16'h0000;
            end
        end else if (CORE.result_valid) begin
            result[CORE.result_index] <= CORE.result_data;
        end
    end

    // PLL reference value taken only during a track-mode run
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pll_ref <= 8'h00;
        end else if (CORE.pll_ref_valid && CTRL.pll_track_mode) begin
            pll_ref <= CORE.pll_ref;
        end
    end

    // Overflow stays set until the measuring unit is initialised
    sticky_flag u_overflow (
        .clk  (CLK),
        .rst_n(RST_N),
        .set  (CORE.overflow_event),
        .clr  (PULSE.init_measure),
        .flag (overflow_flag)
    );

    // Interrupt from the selected source, cleared by either init
    assign irq_set = CTRL.irq_on_overflow ? CORE.overflow_event : CORE.alu_ready;
    assign irq_clr = PULSE.init_measure || PULSE.init_alu;

    sticky_flag u_irq (
        .clk  (CLK),
        .rst_n(RST_N),
        .set  (irq_set),
        .clr  (irq_clr),
        .flag (IRQ_OUT)
    );

    assign status_one = {CORE.pll_lock, overflow_flag, CORE.hit_count_two, CORE.hit_count_one};

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Byte pointer: a new address restarts at the low byte
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            byte_high <= 1'b0;
        end else if (ADDR_LATCH) begin
            byte_high <= 1'b0;
        end else if (rd_end && (addr < ADR_STATUS_ONE)) begin
            byte_high <= !byte_high;
        end
    end

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        rd_word = result[addr[2:0]];
        case (addr)
            ADR_STATUS_ONE: rd_byte = status_one;
            ADR_STATUS_TWO: rd_byte = 8'h00;
            ADR_PLL_REF:    rd_byte = pll_ref;
            default: begin
                if (addr < ADR_STATUS_ONE) begin
                    rd_byte = byte_high ? rd_word[15:8] : rd_word[7:0];
                end else begin
                    rd_byte = 8'h00;
                end
            end
        endcase
    end

    // Data bus driven while read strobe and select are low
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            DATA_OUT <= 8'h00;
            DATA_OE  <= 1'b0;
        end else begin
            DATA_OUT <= rd_byte;
            DATA_OE  <= !CHIP_SELECT_LOW && !READ_STROBE_LOW;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_addr_latch;
        ADDR_LATCH ##1 !ADDR_LATCH [*2] |-> addr == $past(ADDR, 2);
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not held");

    property p_irq_ready;
        !CTRL.irq_on_overflow && CORE.alu_ready |=> IRQ_OUT;
    endproperty
    a_irq_ready: assert property (p_irq_ready) else $error("ready interrupt missing");

    property p_irq_source;
        CTRL.irq_on_overflow && CORE.alu_ready && !CORE.overflow_event && !IRQ_OUT |=> !IRQ_OUT;
    endproperty
    a_irq_source: assert property (p_irq_source) else $error("wrong interrupt source");

    property p_cal_launch;
        wr_stb && (addr == ADR_COMMAND) && wr_data[CAL_BIT] |=> PULSE.cal_run;
    endproperty
    a_cal_launch: assert property (p_cal_launch) else $error("calibration not launched");

    property p_auto_cal;
        CORE.measure_done && wr_reg[ADR_COMMAND][AUTO_CAL_BIT] |=> PULSE.cal_run;
    endproperty
    a_auto_cal: assert property (p_auto_cal) else $error("auto calibration missing");

    property p_start_off;
        CTRL.resolution_adjust |-> !CTRL.start_enable;
    endproperty
    a_start_off: assert property (p_start_off) else $error("start enabled in adjust mode");

    property p_queue_range;
        CTRL.queuing_enable |-> !CTRL.range_two_select;
    endproperty
    a_queue_range: assert property (p_queue_range) else $error("queuing in range two");

    property p_hit_limit;
        CTRL.channel_one_limit <= HIT_MAX && CTRL.channel_two_limit <= HIT_MAX;
    endproperty
    a_hit_limit: assert property (p_hit_limit) else $error("hit limit above four");

    property p_status_lock;
        !CHIP_SELECT_LOW && !READ_STROBE_LOW && addr == ADR_STATUS_ONE
            |=> DATA_OE && DATA_OUT[7] == $past(CORE.pll_lock);
    endproperty
    a_status_lock: assert property (p_status_lock) else $error("status lock bit wrong");

    property p_write_store;
        wr_stb && addr == ADR_RESOLUTION |=> ##1 CTRL.high_res_adjust == $past(wr_data[5:0], 2);
    endproperty
    a_write_store: assert property (p_write_store) else $error("write not stored");

    property p_por_wipe;
        por_wipe |=> ##1 CTRL.multiply_factor == 24'h000000;
    endproperty
    a_por_wipe: assert property (p_por_wipe) else $error("pattern did not wipe");

    c_write: cover property (wr_stb && addr == ADR_COMMAND);
    c_word_read: cover property (rd_end && addr == ADR_MULT_LOW - 4'h8 ##[1:20] rd_end);
    c_irq: cover property ($rose(IRQ_OUT));
    c_overflow: cover property (CORE.overflow_event && CTRL.irq_on_overflow);

endmodule : interval_register_bank

// >>> verilog/interval_bank_pkg.sv
// Purpose: Constants and carrier types of the interval register bank
// Assumes: 8-bit host data bus, 4-bit latched address
// Notes:   Write and read maps share addresses 0x0 to 0xA
package interval_bank_pkg;

    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_COMMAND    = 4'h0;
    localparam logic [3:0] ADR_RESOLUTION = 4'h1;
    localparam logic [3:0] ADR_HIT_SELECT = 4'h2;
    localparam logic [3:0] ADR_PLL_ADJUST = 4'h3;
    localparam logic [3:0] ADR_CLOCK_DIV  = 4'h4;
    localparam logic [3:0] ADR_COMPONENT  = 4'h5;
    localparam logic [3:0] ADR_IRQ_MODE   = 4'h6;
    localparam logic [3:0] ADR_HIT_LIMIT  = 4'h7;
    localparam logic [3:0] ADR_MULT_LOW   = 4'h8;
    localparam logic [3:0] ADR_MULT_MID   = 4'h9;
    localparam logic [3:0] ADR_MULT_HIGH  = 4'hA;
    localparam logic [3:0] ADR_INIT       = 4'hB;
    localparam logic [3:0] ADR_STATUS_ONE = 4'h8;
    localparam logic [3:0] ADR_STATUS_TWO = 4'h9;
    localparam logic [3:0] ADR_PLL_REF    = 4'hA;

    // ------------------------------------------------------------
    // Field positions, values after reset, counts
    // ------------------------------------------------------------
    localparam int CAL_BIT      = 7;
    localparam int ALU_CAL_BIT  = 6;
    localparam int MULT_BIT     = 5;
    localparam int RANGE_BIT    = 4;
    localparam int AUTO_CAL_BIT = 3;
    localparam int INIT_TDC_BIT = 0;
    localparam int INIT_ALU_BIT = 1;
    localparam int NOISE_BIT    = 2;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam logic [3:0] POR_PATTERN = 4'hA;
    localparam logic [2:0] HIT_MAX     = 3'h4;
    localparam int WRITE_REGS   = 11;
    localparam int RESULT_WORDS = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        range_two_select;
        logic        stop_two_polarity;
        logic        stop_one_polarity;
        logic        start_polarity;
        logic        start_enable;
        logic        resolution_adjust;
        logic        high_resolution;
        logic [5:0]  high_res_adjust;
        logic [3:0]  upper_readout_select;
        logic [3:0]  lower_readout_select;
        logic [7:0]  pll_tune_factor;
        logic [2:0]  cal_clock_divider;
        logic        pll_phase_invert;
        logic        pll_track_mode;
        logic [2:0]  pll_ref_divider;
        logic [2:0]  component_port_count;
        logic        single_port;
        logic        capacitor_select;
        logic [2:0]  component_clock_divider;
        logic        irq_on_overflow;
        logic        queuing_enable;
        logic        restart_mode_enable;
        logic        noise_enable;
        logic        component_start;
        logic        external_transistor;
        logic [1:0]  alu_speed;
        logic        half_resolution;
        logic        spike_suppress;
        logic [2:0]  channel_two_limit;
        logic [2:0]  channel_one_limit;
        logic [23:0] multiply_factor;
    } ctrl_type;

    typedef struct packed {
        logic cal_run;
        logic alu_calibrate;
        logic do_multiply;
        logic init_measure;
        logic init_alu;
        logic clock_noise;
    } pulse_type;

    typedef struct packed {
        logic        result_valid;
        logic [2:0]  result_index;
        logic [15:0] result_data;
        logic        measure_done;
        logic        alu_ready;
        logic        overflow_event;
        logic        pll_lock;
        logic [2:0]  hit_count_two;
        logic [2:0]  hit_count_one;
        logic        pll_ref_valid;
        logic [7:0]  pll_ref;
    } core_type;

endpackage : interval_bank_pkg

// >>> verilog/sticky_flag.sv
// Purpose: Flag set by an event and cleared by a command
// Assumes: Set and clear are one-cycle pulses on clk
// Notes:   A set in the clearing cycle wins
module sticky_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Events
    input  wire logic set,
    input  wire logic clr,
    // State
    output logic      flag
);

    // Set has priority so no event is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_set_wins;
        @(posedge clk) disable iff (!rst_n) set |=> flag;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag lost a set");

    property p_clr_only;
        @(posedge clk) disable iff (!rst_n) clr && !set |=> !flag;
    endproperty
    a_clr_only: assert property (p_clr_only) else $error("flag not cleared");

endmodule : sticky_flag

// >>> tb/bus_host.sv
// Purpose: Host model on the multiplexed register bus
// Assumes: Bus pins change at the falling edge of clk
// Notes:   Released data lines show the inverse of the last byte
module bus_host (
    // Clock
    input  wire logic       clk,
    // Bus towards the bank
    output logic [3:0]      addr,
    output logic            latch,
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic [7:0]      data,
    // Read side
    input  wire logic [7:0] rdata,
    input  wire logic       oe,
    output logic            timed_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        {addr, latch, data, timed_out} = '0;
        {cs_n, rd_n, wr_n} = 3'b111;
    end

    // Address held while the latch strobe is high
    task automatic adr(input logic [3:0] a);
        @(negedge clk);
        latch = 1'b1;
        addr  = a;
        @(negedge clk);
        latch = 1'b0;
    endtask : adr

    // Byte stored when the write strobe rises with select low
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        adr(a);
        cs_n = 1'b0;
        wr_n = 1'b0;
        data = d;
        @(negedge clk);
        wr_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b1;
        data = ~d;
        repeat (2) @(negedge clk);
    endtask : wr

    // Read held low until the bank drives the bus; lat=0 keeps the byte pointer
    task automatic rd(input logic [3:0] a, input bit lat, output logic [7:0] d);
        int n;
        if (lat) adr(a);
        else @(negedge clk);
        cs_n = 1'b0;
        rd_n = 1'b0;
        n = 0;
        @(negedge clk);
        while (oe !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        timed_out = (n == 8);
        d = rdata;
        rd_n = 1'b1;
        @(negedge clk);
        cs_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : rd
endmodule : bus_host

// >>> tb/tb.sv
// Purpose: Self-checking bench of the interval register bank
// Assumes: Measuring core levels and pulses driven by the bench
// Notes:   Short pulses are caught in a sticky capture
module tb;
    import interval_bank_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_n, latch, cs_n, rd_n, wr_n, oe, irq, tmo, clr;
    logic [3:0] addr;
    logic [7:0] din, dout, b;
    core_type   core;
    ctrl_type   ctrl;
    pulse_type  pulse, seen;
    int         failures, samples_checked;

    interval_register_bank u_dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .ADDR_LATCH(latch),
        .CHIP_SELECT_LOW(cs_n), .READ_STROBE_LOW(rd_n), .WRITE_STROBE_LOW(wr_n), .DATA_IN(din),
        .DATA_OUT(dout), .DATA_OE(oe), .IRQ_OUT(irq), .CORE(core), .CTRL(ctrl), .PULSE(pulse));
    bus_host u_host (.clk(clk), .addr(addr), .latch(latch), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .data(din), .rdata(dout), .oe(oe), .timed_out(tmo));

    // Clock, and sticky capture of one-cycle pulses
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) seen <= clr ? '0 : (seen | pulse);

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [3:0] a, input bit lat, input logic [7:0] e);
        u_host.rd(a, lat, b);
        if (tmo) failures++;
        if (tmo) end_of_test();
        chk("read", {16'h0, e}, {16'h0, b});
    endtask : rchk

    task automatic t_pulses();
        clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        u_host.wr(ADR_COMMAND, 8'hE9);
        chk("cmd_pulses", 3'b111, {seen.cal_run, seen.alu_calibrate, seen.do_multiply});
        clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        core.measure_done = 1'b1;
        @(negedge clk) core.measure_done = 1'b0;
        repeat (2) @(negedge clk);
        chk("auto_cal", 1'b1, seen.cal_run);
        u_host.wr(ADR_COMMAND, 8'h16);
        chk("range_edges", 4'hE, {ctrl.range_two_select, ctrl.stop_two_polarity,
            ctrl.stop_one_polarity, ctrl.start_polarity});
    endtask : t_pulses

    task automatic t_fields();
        u_host.wr(ADR_RESOLUTION, 8'hCD);
        chk("resolution", 9'h0CD, {ctrl.start_enable, ctrl.resolution_adjust, ctrl.high_resolution,
            ctrl.high_res_adjust});
        u_host.wr(ADR_HIT_SELECT, 8'hA5);
        chk("readout", 8'hA5, {ctrl.upper_readout_select, ctrl.lower_readout_select});
        u_host.wr(ADR_PLL_ADJUST, 8'h81);
        chk("pll_tune", 8'h81, ctrl.pll_tune_factor);
        u_host.wr(ADR_CLOCK_DIV, 8'hA9);
        chk("clock", 8'hA9, {ctrl.cal_clock_divider, ctrl.pll_phase_invert, ctrl.pll_track_mode,
            ctrl.pll_ref_divider});
        u_host.wr(ADR_COMPONENT, 8'h7D);
        chk("component", 8'h7D, {ctrl.component_port_count, ctrl.single_port, ctrl.capacitor_select,
            ctrl.component_clock_divider});
        u_host.wr(ADR_IRQ_MODE, 8'h43);
        chk("queue_speed", 3'b011, {ctrl.queuing_enable, ctrl.alu_speed});
        u_host.wr(ADR_HIT_LIMIT, 8'hBF);
        chk("hit_limit", 8'hA4, {ctrl.half_resolution, ctrl.spike_suppress, ctrl.channel_two_limit,
            ctrl.channel_one_limit});
        u_host.wr(ADR_MULT_LOW, 8'h12);
        u_host.wr(ADR_MULT_MID, 8'h34);
        u_host.wr(ADR_MULT_HIGH, 8'h56);
        chk("multiply", 24'h563412, ctrl.multiply_factor);
    endtask : t_fields

    task automatic t_irq();
        core.alu_ready = 1'b1;
        @(negedge clk) core.alu_ready = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq_alu", 1'b1, irq);
        u_host.wr(ADR_INIT, 8'h02);
        chk("irq_alu_cleared", 1'b0, irq);
        u_host.wr(ADR_IRQ_MODE, 8'h80);
        core.alu_ready = 1'b1;
        @(negedge clk) core.alu_ready = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq_alu_masked", 1'b0, irq);
        core.overflow_event = 1'b1;
        @(negedge clk) core.overflow_event = 1'b0;
        repeat (2) @(negedge clk);
        chk("irq_overflow", 1'b1, irq);
        rchk(ADR_STATUS_ONE, 1, 8'hDA);
        clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        u_host.wr(ADR_INIT, 8'h07);
        chk("init_pulses", 3'b111, {seen.init_measure, seen.init_alu, seen.clock_noise});
        chk("irq_cleared", 1'b0, irq);
    endtask : t_irq

    task automatic t_reads();
        core.result_index = 3'h2;
        core.result_data = 16'hBEEF;
        core.result_valid = 1'b1;
        core.pll_ref = 8'h5C;
        core.pll_ref_valid = 1'b1;
        @(negedge clk) {core.result_valid, core.pll_ref_valid} = 2'b00;
        rchk(4'h2, 1, 8'hEF);
        rchk(4'h2, 0, 8'hBE);
        rchk(ADR_PLL_REF, 1, 8'h5C);
        rchk(ADR_STATUS_TWO, 1, 8'h00);
        rchk(4'hC, 1, 8'h00);
        u_host.wr(ADR_INIT, 8'hA0);
        chk("por_wipe", 24'h000000, ctrl.multiply_factor);
    endtask : t_reads

    // Reset, then scenarios in order
    initial begin
        {failures, samples_checked, clr} = '0;
        core = '0;
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk("reset_ctrl", 2'b10, {ctrl.start_enable, ctrl.range_two_select});
        chk("reset_irq", 1'b0, irq);
        rchk(ADR_STATUS_ONE, 1, 8'h00);
        {core.pll_lock, core.hit_count_two, core.hit_count_one} = 7'h5A;
        t_pulses();
        t_fields();
        t_irq();
        t_reads();
        end_of_test();
    end
endmodule : tb
